// ### cri_regs.vh
// Purpose: shared constants of the cpu reset initializer
// Assumes: included by bare name from each design file
// Notes: offsets are byte addresses on the axi4-lite register bus
`ifndef CRI_REGS_VH
`define CRI_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define CRI_OFS_STATUS 8'h00
`define CRI_OFS_PC 8'h04
`define CRI_OFS_SP 8'h08
`define CRI_OFS_SW 8'h0c
`define CRI_OFS_GEAR 8'h10
`define CRI_OFS_PORTF 8'h14

////////////////////////////////////////////////////////////////////////////////
// status word field positions
`define CRI_SW_MASK_HI 14
`define CRI_SW_MASK_LO 12
`define CRI_SW_WIDE_BIT 11
`define CRI_SW_BANK_HI 10
`define CRI_SW_BANK_LO 8

////////////////////////////////////////////////////////////////////////////////
// values loaded when a reset is accepted; CRI_SW_POR and CRI_PC_POR load at bus reset only
`define CRI_VEC_ADDR0 24'hffff00
`define CRI_VEC_ADDR1 24'hffff01
`define CRI_VEC_ADDR2 24'hffff02
`define CRI_SP_RESET 32'h00000100
`define CRI_MASK_RESET 3'h7
`define CRI_WIDE_RESET 1'h1
`define CRI_BANK_RESET 3'h0
`define CRI_SW_POR 16'h0000
`define CRI_PC_POR 24'h000000
`define CRI_GEAR_RESET 3'h4
`define CRI_PORTF_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
// timing: least low time of the reset pin, in system clocks
`define CRI_RST_MIN_SYSCLK 10
// oscillator cycles per system clock in the reset gear (fc/32)
`define CRI_GEAR_RESET_DIV 32
`define CRI_RST_MIN_CYC (`CRI_RST_MIN_SYSCLK * `CRI_GEAR_RESET_DIV)

`endif

// ### cri_reset_init.v
// Purpose: reset acceptance and cpu state initialisation
// Assumes: aclk is fc at 100 MHz, vector bytes read over a byte port
// Notes: registers reached over axi4-lite, one aligned word each
// Summary of operation
// - reset selects gear one-sixteenth, fc over 32
// - program counter loaded from three vector bytes
// - stack pointer set to hex 100
// - interrupt mask level set to seven
// - wide address mode bit set to one
// - register bank pointer cleared to zero
// - core starts at vector-loaded program counter
// - other cpu state and ram untouched
// - peripheral io registers return to initial values
// - every port pin returns to general-purpose
`timescale 1ns/1ps
`include "cri_regs.vh"

module cri_reset_init #(
  parameter MIN_CYC = `CRI_RST_MIN_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire rst_pin_n,
  output reg core_hold_q,
  output reg core_start_q,
  output reg io_init_q,
  output reg sys_en_q,
  output reg [2:0] gear_q,
  output reg [7:0] port_func_q,
  output reg [23:0] pc_q,
  output reg [31:0] sp_q,
  output reg [15:0] sw_q,
  output reg vec_req_q,
  output reg [23:0] vec_addr_q,
  input wire vec_ack,
  input wire [7:0] vec_rdata,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam ST_RUN = 3'h0;
  localparam ST_HOLD = 3'h1;
  localparam ST_FETCH = 3'h2;
  localparam ST_LOAD = 3'h3;

  wire accept;
  wire release_p;
  reg [2:0] state_q;
  reg [1:0] byte_q;
  reg [23:0] vec_q;
  reg [7:0] accept_cnt_q;
  reg [4:0] div_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aresetn_seen_q;
  wire do_write;
  wire hw_load;
  wire [31:0] pc_merged;
  wire [31:0] sw_merged;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = din[i*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CRI_OFS_STATUS) || (a == `CRI_OFS_PC) || (a == `CRI_OFS_SP) ||
               (a == `CRI_OFS_SW) || (a == `CRI_OFS_GEAR) || (a == `CRI_OFS_PORTF);
    end
  endfunction

  function [4:0] gear_top;
    input [2:0] g;
    begin
      case (g)
        3'h0: gear_top = 5'h01;
        3'h1: gear_top = 5'h03;
        3'h2: gear_top = 5'h07;
        3'h3: gear_top = 5'h0f;
        default: gear_top = 5'h1f;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset pin qualifier
  cri_rst_qual #(
    .MIN_CYC(MIN_CYC)
  ) u_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .rst_pin_n(rst_pin_n),
    .accept_q(accept),
    .release_q(release_p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: hold, vector fetch, load, run
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_HOLD;
      byte_q <= 2'h0;
      vec_q <= 24'h000000;
      vec_req_q <= 1'b0;
      vec_addr_q <= 24'h000000;
      core_hold_q <= 1'b1;
      core_start_q <= 1'b0;
      io_init_q <= 1'b1;
      accept_cnt_q <= 8'h00;
    end else begin
      core_start_q <= 1'b0;
      if (accept) begin
        if (state_q != ST_HOLD) begin
          accept_cnt_q <= accept_cnt_q + 8'h01;
        end
        state_q <= ST_HOLD;
        vec_req_q <= 1'b0;
        core_hold_q <= 1'b1;
        io_init_q <= 1'b1;
      end else begin
        case (state_q)
          ST_HOLD: begin
            if (release_p || !aresetn_seen_q) begin
              state_q <= ST_FETCH;
              byte_q <= 2'h0;
              io_init_q <= 1'b0;
              vec_req_q <= 1'b1;
              vec_addr_q <= `CRI_VEC_ADDR0;
            end
          end
          ST_FETCH: begin
            if (vec_ack) begin
              // byte 0 low, byte 2 high
              vec_q[byte_q*8 +: 8] <= vec_rdata;
              if (byte_q == 2'h2) begin
                vec_req_q <= 1'b0;
                state_q <= ST_LOAD;
              end else begin
                byte_q <= byte_q + 2'h1;
                vec_addr_q <= (byte_q == 2'h0) ? `CRI_VEC_ADDR1 : `CRI_VEC_ADDR2;
              end
            end
          end
          ST_LOAD: begin
            state_q <= ST_RUN;
            core_hold_q <= 1'b0;
            core_start_q <= 1'b1;
          end
          ST_RUN: begin
            core_hold_q <= 1'b0;
          end
          default: begin
            state_q <= ST_HOLD;
          end
        endcase
      end
    end
  end

  // after bus reset, boot once without waiting for a pin pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      aresetn_seen_q <= 1'b0;
    end else if (state_q == ST_FETCH) begin
      aresetn_seen_q <= 1'b1;
    end
  end

  assign hw_load = (state_q == ST_LOAD) && !accept;

  // byte-lane merges of a pending write into pc and sw
  assign pc_merged = merge({8'h00, pc_q}, wdata_q, wstrb_q);
  assign sw_merged = merge({16'h0000, sw_q}, wdata_q, wstrb_q);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel capture
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu-visible state; hardware load wins over a software write
  always @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= `CRI_PC_POR;
      sp_q <= `CRI_SP_RESET;
      sw_q <= `CRI_SW_POR;
    end else if (hw_load) begin
      pc_q <= vec_q;
      sp_q <= `CRI_SP_RESET;
      // flag bits of the status word keep their value
      sw_q[`CRI_SW_MASK_HI:`CRI_SW_MASK_LO] <= `CRI_MASK_RESET;
      sw_q[`CRI_SW_WIDE_BIT] <= `CRI_WIDE_RESET;
      sw_q[`CRI_SW_BANK_HI:`CRI_SW_BANK_LO] <= `CRI_BANK_RESET;
    end else if (do_write) begin
      if (awaddr_q == `CRI_OFS_PC) begin
        pc_q <= pc_merged[23:0];
      end
      if (awaddr_q == `CRI_OFS_SP) begin
        sp_q <= merge(sp_q, wdata_q, wstrb_q);
      end
      if (awaddr_q == `CRI_OFS_SW) begin
        // mode bit stored as written; software must keep it at one
        sw_q <= sw_merged[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock gear and port function, forced while reset is accepted
  always @(posedge aclk) begin
    if (!aresetn) begin
      gear_q <= `CRI_GEAR_RESET;
      port_func_q <= `CRI_PORTF_RESET;
    end else if (accept) begin
      gear_q <= `CRI_GEAR_RESET;
      port_func_q <= `CRI_PORTF_RESET;
    end else if (do_write) begin
      if ((awaddr_q == `CRI_OFS_GEAR) && wstrb_q[0]) begin
        gear_q <= (wdata_q[2:0] > `CRI_GEAR_RESET) ? `CRI_GEAR_RESET : wdata_q[2:0];
      end
      if ((awaddr_q == `CRI_OFS_PORTF) && wstrb_q[0]) begin
        port_func_q <= wdata_q[7:0];
      end
    end
  end

  // system clock enable: one pulse every 2 << gear oscillator cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 5'h00;
      sys_en_q <= 1'b0;
    end else if (accept || div_q >= gear_top(gear_q)) begin
      div_q <= 5'h00;
      sys_en_q <= !accept || (div_q >= gear_top(gear_q));
    end else begin
      div_q <= div_q + 5'h01;
      sys_en_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel, answer one cycle after address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
        case (s_axi_araddr)
          `CRI_OFS_STATUS: s_axi_rdata <= {16'h0000, accept_cnt_q, 3'h0,
                                           core_hold_q, accept, state_q};
          `CRI_OFS_PC: s_axi_rdata <= {8'h00, pc_q};
          `CRI_OFS_SP: s_axi_rdata <= sp_q;
          `CRI_OFS_SW: s_axi_rdata <= {16'h0000, sw_q};
          `CRI_OFS_GEAR: s_axi_rdata <= {29'h00000000, gear_q};
          `CRI_OFS_PORTF: s_axi_rdata <= {24'h000000, port_func_q};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // cri_reset_init

// ### cri_reset_init_bench.sv
// Purpose: self-checking bench for the reset initializer
// Assumes: axi4-lite master tasks and a vector memory partner
// Notes: a short MIN_CYC keeps the pin pulses brief
`timescale 1ns/1ps

module cri_reset_init_bench;
  localparam MIN = 16;
  localparam [23:0] VEC = 24'h123456;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg rst_pin_n = 1'b1;
  reg [3:0] lat = 4'h0;
  reg [7:0] awaddr = 8'h0, araddr = 8'h0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'hf;
  reg awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  wire core_hold_q, core_start_q, io_init_q, vec_req_q, vec_ack;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [2:0] gear_q;
  wire [7:0] port_func_q, vec_rdata;
  wire [15:0] sw_q;
  wire [23:0] pc_q, vec_addr_q;
  wire [31:0] sp_q, rdata;
  integer failures = 0, samples_checked = 0, k;

  always #5 aclk = ~aclk;

  cri_reset_init #(.MIN_CYC(MIN)) dut (.aclk(aclk), .aresetn(aresetn),
    .rst_pin_n(rst_pin_n), .core_hold_q(core_hold_q), .core_start_q(core_start_q),
    .io_init_q(io_init_q), .sys_en_q(), .gear_q(gear_q), .port_func_q(port_func_q),
    .pc_q(pc_q), .sp_q(sp_q), .sw_q(sw_q), .vec_req_q(vec_req_q),
    .vec_addr_q(vec_addr_q), .vec_ack(vec_ack), .vec_rdata(vec_rdata),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  cri_vec_rom #(.VEC(VEC)) u_rom (.aclk(aclk), .lat(lat), .vec_req_q(vec_req_q),
    .vec_addr_q(vec_addr_q), .vec_ack(vec_ack), .vec_rdata(vec_rdata));

  ////////////////////////////////////////
  task give_verdict;
    begin
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  task tout;
    begin
      failures = failures + 1;
      give_verdict;
    end
  endtask

  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    reg done;
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n = n + 1) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          done = 1'b1;
          chk(32'(bresp), 32'(r));
        end
      end
      if (!done) tout;
    end
  endtask

  task rd(input [7:0] a, input [31:0] e, input [1:0] r);
    integer n;
    reg done;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n = n + 1) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          done = 1'b1;
          chk(rdata, e);
          chk(32'(rresp), 32'(r));
        end
      end
      if (!done) tout;
    end
  endtask

  // wait for the start pulse, then compare the loaded core state
  task wait_start(input [15:0] e);
    integer n;
    begin
      for (n = 0; n < 400 && core_start_q !== 1'b1; n = n + 1) @(posedge aclk);
      if (n == 400) tout;
      chk(32'(pc_q), 32'(VEC));
      chk(sp_q, 32'h100);
      chk(32'(sw_q), 32'(e));
      chk(32'(core_hold_q), 32'h0);
    end
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wait_start(16'h7800);
    rd(8'h10, 32'h4, 2'b00);
    rd(8'h14, 32'h0, 2'b00);
    rd(8'h04, {8'h0, VEC}, 2'b00);
    wr(8'h0c, 32'h8ba5, 2'b00);
    wr(8'h40, 32'h1, 2'b10);
    rd(8'h40, 32'h0, 2'b10);
    for (k = 0; k < 2; k = k + 1) begin
      lat <= k ? 4'h3 : 4'h0;
      wr(8'h14, 32'h3c, 2'b00);
      rd(8'h14, 32'h3c, 2'b00);
      wr(8'h10, 32'h1, 2'b00);
      rd(8'h10, 32'h1, 2'b00);
      wr(8'h08, 32'hbeef, 2'b00);
      rst_pin_n <= 1'b0;
      repeat (MIN / 2) @(posedge aclk);
      rst_pin_n <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(32'(core_hold_q), 32'h0);
      rd(8'h08, 32'hbeef, 2'b00);
      rst_pin_n <= 1'b0;
      repeat (MIN + 6) @(posedge aclk);
      chk(32'(core_hold_q), 32'h1);
      chk(32'(io_init_q), 32'h1);
      chk(32'(gear_q), 32'h4);
      chk(32'(port_func_q), 32'h0);
      rst_pin_n <= 1'b1;
      wait_start(16'hf8a5);
      rd(8'h08, 32'h100, 2'b00);
    end
    give_verdict;
  end
endmodule // cri_reset_init_bench

// ### cri_reset_init_monitor.sv
// Purpose: concurrent checks on the reset initializer ports
// Assumes: bound to every instance of the top module
// Notes: helper counters track pin low time and gear period
`timescale 1ns/1ps

module cri_monitor #(
  parameter MIN_CYC = 320
) (
  input wire aclk,
  input wire aresetn,
  input wire rst_pin_n,
  input wire core_hold_q,
  input wire core_start_q,
  input wire io_init_q,
  input wire sys_en_q,
  input wire [2:0] gear_q,
  input wire [7:0] port_func_q,
  input wire [23:0] pc_q,
  input wire [31:0] sp_q,
  input wire [15:0] sw_q,
  input wire vec_req_q,
  input wire [23:0] vec_addr_q,
  input wire vec_ack,
  input wire [7:0] vec_rdata
);
  reg [23:0] vec_q = 24'h0;
  reg [15:0] low_q = 16'h0;
  reg [5:0] gap_q = 6'h0;
  reg seen_q = 1'b0;

  // bytes taken, pin low run, cycles between enables
  always @(posedge aclk) begin
    if (vec_req_q && vec_ack) vec_q[8 * vec_addr_q[1:0] +: 8] <= vec_rdata;
    low_q <= rst_pin_n ? 16'h0 : low_q + {15'h0, low_q != 16'hffff};
    if (!aresetn || core_hold_q || gear_q != 3'h4) begin
      gap_q <= 6'h0;
      seen_q <= 1'b0;
    end else if (sys_en_q) begin
      gap_q <= 6'h0;
      seen_q <= 1'b1;
    end else gap_q <= gap_q + 6'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pc_vector: assert property (core_start_q |-> pc_q == vec_q)
    else $error("pc differs from vector bytes");
  a_sp_load: assert property (core_start_q |-> sp_q == 32'h100)
    else $error("stack pointer not 100 at start");
  a_mask_seven: assert property (core_start_q |-> sw_q[14:12] == 3'h7)
    else $error("mask level not seven at start");
  a_wide_mode: assert property (core_start_q |-> sw_q[11])
    else $error("wide mode bit clear at start");
  a_bank_zero: assert property (core_start_q |-> sw_q[10:8] == 3'h0)
    else $error("bank pointer not zero at start");
  a_start_once: assert property (core_start_q |->
    !core_hold_q && $past(core_hold_q) ##1 !core_start_q)
    else $error("start pulse malformed");
  a_gear_div: assert property (sys_en_q && seen_q && gear_q == 3'h4 |-> gap_q == 6'd31)
    else $error("enable period not 32 in slow gear");
  a_accept_len: assert property ($rose(core_hold_q) |-> low_q >= MIN_CYC)
    else $error("reset accepted on short pulse");
  a_io_init: assert property ($rose(core_hold_q) |-> ##[0:2] io_init_q)
    else $error("io init missing after accept");
  a_port_gp: assert property (core_hold_q && !rst_pin_n |=>
    gear_q == 3'h4 && port_func_q == 8'h00)
    else $error("gear or port function not reset");

  c_start: cover property (core_start_q);
  c_accept: cover property ($rose(core_hold_q));
  c_byte: cover property (vec_req_q && vec_ack);
endmodule // cri_monitor

bind cri_reset_init cri_monitor #(.MIN_CYC(MIN_CYC)) u_monitor (.aclk(aclk),
  .aresetn(aresetn), .rst_pin_n(rst_pin_n), .core_hold_q(core_hold_q),
  .core_start_q(core_start_q), .io_init_q(io_init_q), .sys_en_q(sys_en_q),
  .gear_q(gear_q), .port_func_q(port_func_q), .pc_q(pc_q), .sp_q(sp_q), .sw_q(sw_q),
  .vec_req_q(vec_req_q), .vec_addr_q(vec_addr_q), .vec_ack(vec_ack),
  .vec_rdata(vec_rdata));

// ### cri_rst_qual.v
// Purpose: synchronise the reset pin and qualify its low time
// Assumes: aclk is the oscillator clock fc
// Notes: accept rises once the pin has been low for MIN_CYC cycles
`timescale 1ns/1ps
`include "cri_regs.vh"

module cri_rst_qual #(
  parameter MIN_CYC = `CRI_RST_MIN_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire rst_pin_n,
  output reg accept_q,
  output reg release_q
);

  reg sync1_q;
  reg sync2_q;
  reg [15:0] low_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser, counter sees only the second stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= rst_pin_n;
      sync2_q <= sync1_q;
    end
  end

  // low-time counter, accept level and one-cycle release pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_q <= 16'h0000;
      accept_q <= 1'b0;
      release_q <= 1'b0;
    end else begin
      release_q <= 1'b0;
      if (sync2_q) begin
        low_cnt_q <= 16'h0000;
        release_q <= accept_q;
        accept_q <= 1'b0;
      end else if (low_cnt_q == MIN_CYC[15:0] - 16'h0001) begin
        accept_q <= 1'b1;
      end else begin
        low_cnt_q <= low_cnt_q + 16'h0001;
      end
    end
  end

endmodule // cri_rst_qual

// ### cri_vec_rom.sv
// Purpose: vector byte memory on the far side of the fetch port
// Assumes: one byte answered per request, after lat idle cycles
// Notes: data lines toggle whenever no byte is being handed over
`timescale 1ns/1ps

module cri_vec_rom #(
  parameter [23:0] VEC = 24'h123456
) (
  input wire aclk,
  input wire [3:0] lat,
  input wire vec_req_q,
  input wire [23:0] vec_addr_q,
  output reg vec_ack = 1'b0,
  output reg [7:0] vec_rdata = 8'h00
);
  reg [3:0] cnt_q = 4'h0;

  // answer a held request after lat cycles, one ack per byte
  always @(posedge aclk) begin
    vec_ack <= 1'b0;
    vec_rdata <= ~vec_rdata;
    if (vec_req_q && !vec_ack && cnt_q >= lat) begin
      vec_ack <= 1'b1;
      cnt_q <= 4'h0;
      vec_rdata <= VEC[8 * vec_addr_q[1:0] +: 8];
    end else if (vec_req_q && !vec_ack) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // cri_vec_rom
